// >>> rtl/crc_check_pkg.sv
// shared constants and carriers for the config memory crc checker
package crc_check_pkg;
  localparam int CRC_W = 32;
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;
  localparam logic [31:0] REF_RESET = 32'h00000000;
  localparam int FRAME_CRC_W = 16;
  localparam logic [15:0] FRAME_POLY = 16'h8005;
  localparam logic [15:0] FRAME_INIT = 16'hffff;
  localparam int IR_W = 10;
  localparam logic [9:0] LOAD_REF_INSTR = 10'h015;
  localparam int OSC_KHZ = 80000;
  localparam int DIV_MAX = 8;
  localparam logic [3:0] DIV_RESET = 4'h0;
  localparam logic OPEN_DRAIN_RESET = 1'b0;

  typedef enum logic [1:0] {
    ST_CONFIG = 2'b00,
    ST_CFG_FAIL = 2'b01,
    ST_USER = 2'b10
  } mode_e;

  // scan port from the boundary-scan tap controller
  typedef struct packed {
    logic [9:0] ir;
    logic tdi;
    logic capture_dr;
    logic shift_dr;
    logic update_dr;
  } scan_s;

  // configuration stream word
  typedef struct packed {
    logic valid;
    logic data;
    logic frame_end;
    logic last_frame;
    logic ref_bit;
  } cfg_s;
endpackage

// >>> rtl/crc_serial_step.sv
// one serial step of a galois crc register
`timescale 1ns/1ps
`default_nettype none
module crc_serial_step #(
  parameter int W = 32,
  parameter logic [W-1:0] POLY = '0
) (
  input wire logic [W-1:0] crc_in,
  input wire logic bit_in,
  output logic [W-1:0] crc_out
);
  logic fb;
  always_comb begin
    fb = crc_in[W-1] ^ bit_in;
    crc_out = {crc_in[W-2:0], 1'b0} ^ (fb ? POLY : '0);
  end
endmodule
`default_nettype wire

// >>> rtl/clk_pulse_div.sv
// divides the base clock by 2 to the n into a tick pulse
`timescale 1ns/1ps
`default_nettype none
module clk_pulse_div #(
  parameter int MAX_N = 8
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [3:0] div_n_in,
  output logic tick_out
);
  logic [MAX_N-1:0] cnt_r, cnt_nxt;
  logic [MAX_N-1:0] mask;
  logic tick_r, tick_nxt;
  always_comb begin
    mask = MAX_N'((1 << div_n_in) - 1);
    cnt_nxt = cnt_r + 1'b1;
    tick_nxt = ((cnt_r & mask) == mask);
  end
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      cnt_r <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end
  assign tick_out = tick_r;
endmodule
`default_nettype wire

// >>> rtl/config_memory_crc_checker.sv
// configuration memory crc checker: frame checks, scrub, reference load
`timescale 1ns/1ps
`default_nettype none
// What this block does
// [RL1] per frame crc checked in config; stop on mismatch or after last frame
// [RL2] capture stream reference crc into 32-bit store at config end
// [RL3] in user mode repeatedly crc all config cells against reference
// [RL4] checking runs until reconfig_request_n goes low
// [RL5] only configuration cells scanned, no memory blocks or io state
// [RL6] ieee 802 32-bit polynomial, one signature per pass
// [RL7] error output 0 for zero signature, 1 for nonzero
// [RL8] reference and option bits kept in flip-flops
// [RL9] instruction 00 0001 0101 puts reference store between tdi and tdo
// [RL10] reference load instruction honoured only in user mode
// [RL11] host may restore correct reference with same instruction
// [RL12] host should read out reference before writing a bad one
// [RL13] power cycle recommended after fault injection test
// [RL14] error pin push-pull by default, open-drain by option
// [RL15] monitor pulses reconfig request or ignores the error
// [RL16] error held through next pass, cleared after a clean pass
// [RL17] checker clocked by 80 mhz over 2 to the n, n 0 to 8
// [RL18] reference load never stops normal operation
// [RL19] new reference takes effect at start of next full pass
module config_memory_crc_checker #(
  parameter int CELL_AW = 16,
  parameter logic [CELL_AW-1:0] CELL_LAST = '1
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic reconfig_request_n_in,
  input wire crc_check_pkg::cfg_s cfg_in,
  input wire crc_check_pkg::scan_s scan_in,
  input wire logic [3:0] div_n_in,
  input wire logic open_drain_opt_in,
  input wire logic cell_bit_in,
  output logic [CELL_AW-1:0] cell_addr_out,
  output logic tdo_out,
  output logic cfg_error_out,
  output logic cfg_done_out,
  output logic crc_error_out,
  output logic crc_error_oe_out
);
  ////////////////////////////////////////////////////////////////////////
  // input synchronisers
  // reconfig pin is asynchronous: two stages first
  logic rq_s1_r, rq_s2_r;
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      rq_s1_r <= 1'b1;
      rq_s2_r <= 1'b1;
    end else begin
      rq_s1_r <= reconfig_request_n_in;
      rq_s2_r <= rq_s1_r;
    end
  end
  logic reset_all;
  assign reset_all = rst_in | ~rq_s2_r; // see [RL4]

  ////////////////////////////////////////////////////////////////////////
  // configuration phase
  crc_check_pkg::mode_e mode_r, mode_nxt;
  logic [15:0] fcrc_r, fcrc_nxt, fcrc_step;
  logic [15:0] fsh_r, fsh_nxt;
  logic [4:0] fcnt_r, fcnt_nxt;
  logic in_crc_r, in_crc_nxt;
  logic [31:0] ref_r, ref_nxt;
  logic [31:0] refsh_r, refsh_nxt;
  logic [3:0] div_r, div_nxt;
  logic od_r, od_nxt;
  logic cfg_err_r, cfg_err_nxt;

  crc_serial_step #(
    .W(crc_check_pkg::FRAME_CRC_W),
    .POLY(crc_check_pkg::FRAME_POLY)
  ) u_frame_step (
    .crc_in(fcrc_r),
    .bit_in(cfg_in.data),
    .crc_out(fcrc_step)
  );

  // scan shift chain of the reference store
  logic ir_match;
  logic instr_ok;
  assign ir_match =
    (scan_in.ir == crc_check_pkg::LOAD_REF_INSTR); // see [RL9]
  // refused outside user mode, no indication
  assign instr_ok = ir_match
    && (mode_r == crc_check_pkg::ST_USER); // see [RL10]

  always_comb begin
    mode_nxt = mode_r;
    fcrc_nxt = fcrc_r;
    fsh_nxt = fsh_r;
    fcnt_nxt = fcnt_r;
    in_crc_nxt = in_crc_r;
    ref_nxt = ref_r;
    refsh_nxt = refsh_r;
    div_nxt = div_r;
    od_nxt = od_r;
    cfg_err_nxt = cfg_err_r;
    unique case (mode_r)
      crc_check_pkg::ST_CONFIG: begin
        if (cfg_in.valid) begin
          if (!in_crc_r) begin
            fcrc_nxt = fcrc_step; // see [RL1]
            if (cfg_in.frame_end) begin
              in_crc_nxt = 1'b1;
              fcnt_nxt = '0;
            end
          end else if (cfg_in.last_frame && cfg_in.frame_end) begin
            // reference crc shifted in between last data and its crc
            refsh_nxt = {refsh_r[30:0], cfg_in.ref_bit}; // see [RL2]
          end else begin
            fsh_nxt = {fsh_r[14:0], cfg_in.data};
            fcnt_nxt = fcnt_r + 5'h01;
            if (fcnt_r == 5'h0f) begin
              in_crc_nxt = 1'b0;
              fcrc_nxt = crc_check_pkg::FRAME_INIT;
              if ({fsh_r[14:0], cfg_in.data} != fcrc_r) begin
                mode_nxt = crc_check_pkg::ST_CFG_FAIL; // see [RL1]
                cfg_err_nxt = 1'b1;
              end else if (cfg_in.last_frame) begin
                mode_nxt = crc_check_pkg::ST_USER;
                ref_nxt = refsh_r; // see [RL2] see [RL8]
                // divisor above the largest is clamped
                div_nxt = (div_n_in > 4'(crc_check_pkg::DIV_MAX))
                  ? 4'(crc_check_pkg::DIV_MAX) : div_n_in; // see [RL17]
                od_nxt = open_drain_opt_in; // see [RL14] see [RL8]
              end
            end
          end
        end
      end
      crc_check_pkg::ST_CFG_FAIL: begin
        // loading halted until reconfig
      end
      crc_check_pkg::ST_USER: begin
        if (instr_ok && scan_in.capture_dr) begin
          refsh_nxt = ref_r; // see [RL12]
        end else if (instr_ok && scan_in.shift_dr) begin
          refsh_nxt = {scan_in.tdi, refsh_r[31:1]}; // see [RL9]
        end else if (instr_ok && scan_in.update_dr) begin
          ref_nxt = refsh_r; // see [RL11] see [RL18]
        end
      end
      default: mode_nxt = crc_check_pkg::ST_CONFIG;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_all) begin
      mode_r <= crc_check_pkg::ST_CONFIG;
      fcrc_r <= crc_check_pkg::FRAME_INIT;
      fsh_r <= '0;
      fcnt_r <= '0;
      in_crc_r <= 1'b0;
      ref_r <= crc_check_pkg::REF_RESET;
      refsh_r <= crc_check_pkg::REF_RESET;
      div_r <= crc_check_pkg::DIV_RESET;
      od_r <= crc_check_pkg::OPEN_DRAIN_RESET;
      cfg_err_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      fcrc_r <= fcrc_nxt;
      fsh_r <= fsh_nxt;
      fcnt_r <= fcnt_nxt;
      in_crc_r <= in_crc_nxt;
      ref_r <= ref_nxt;
      refsh_r <= refsh_nxt;
      div_r <= div_nxt;
      od_r <= od_nxt;
      cfg_err_r <= cfg_err_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // user mode scrub
  // tick phase runs free; a pass counts ticks
  logic tick;
  clk_pulse_div #(
    .MAX_N(crc_check_pkg::DIV_MAX)
  ) u_div (
    .core_clk_in(core_clk_in),
    .rst_in(reset_all),
    .div_n_in(div_r),
    .tick_out(tick)
  ); // see [RL17]

  logic [CELL_AW-1:0] addr_r, addr_nxt;
  logic [31:0] scrc_r, scrc_nxt, scrc_step;
  logic [31:0] pass_ref_r, pass_ref_nxt;
  logic [5:0] rcnt_r, rcnt_nxt;
  logic tail_r, tail_nxt;
  logic err_r, err_nxt;
  logic crc_bit;

  // cell bits then the reference, so a clean pass leaves zero
  assign crc_bit = tail_r ? pass_ref_r[31] : cell_bit_in; // see [RL5]

  crc_serial_step #(
    .W(crc_check_pkg::CRC_W),
    .POLY(crc_check_pkg::CRC_POLY)
  ) u_scrub_step (
    .crc_in(scrc_r),
    .bit_in(crc_bit),
    .crc_out(scrc_step)
  ); // see [RL6]

  always_comb begin
    addr_nxt = addr_r;
    scrc_nxt = scrc_r;
    pass_ref_nxt = pass_ref_r;
    rcnt_nxt = rcnt_r;
    tail_nxt = tail_r;
    err_nxt = err_r;
    if (mode_r != crc_check_pkg::ST_USER) begin
      addr_nxt = '0;
      scrc_nxt = crc_check_pkg::CRC_INIT;
      pass_ref_nxt = ref_nxt;
      rcnt_nxt = '0;
      tail_nxt = 1'b0;
    end else if (tick) begin
      scrc_nxt = scrc_step; // see [RL3]
      if (!tail_r) begin
        addr_nxt = addr_r + 1'b1;
        if (addr_r == CELL_LAST) begin
          tail_nxt = 1'b1;
          addr_nxt = '0;
        end
      end else begin
        pass_ref_nxt = {pass_ref_r[30:0], 1'b0};
        rcnt_nxt = rcnt_r + 6'h01;
        if (rcnt_r == 6'h1f) begin
          // pass done: signature decides error, restart
          err_nxt = (scrc_step != 32'h00000000); // see [RL7] see [RL16]
          scrc_nxt = crc_check_pkg::CRC_INIT; // see [RL3]
          pass_ref_nxt = ref_r; // see [RL19]
          rcnt_nxt = '0;
          tail_nxt = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (reset_all) begin
      addr_r <= '0;
      scrc_r <= crc_check_pkg::CRC_INIT;
      pass_ref_r <= crc_check_pkg::REF_RESET;
      rcnt_r <= '0;
      tail_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      addr_r <= addr_nxt;
      scrc_r <= scrc_nxt;
      pass_ref_r <= pass_ref_nxt;
      rcnt_r <= rcnt_nxt;
      tail_r <= tail_nxt;
      err_r <= err_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output registers
  logic tdo_r, tdo_nxt;
  logic pin_r, pin_nxt;
  logic oe_r, oe_nxt;
  logic done_r, done_nxt;
  always_comb begin
    tdo_nxt = refsh_nxt[0];
    done_nxt = (mode_nxt == crc_check_pkg::ST_USER);
    // open drain: pin released for an error, pulled high
    if (od_nxt) begin
      pin_nxt = 1'b0;
      oe_nxt = ~err_nxt; // see [RL14]
    end else begin
      pin_nxt = err_nxt; // see [RL7]
      oe_nxt = 1'b1;
    end
  end
  always_ff @(posedge core_clk_in) begin
    if (reset_all) begin
      tdo_r <= 1'b0;
      pin_r <= 1'b0;
      oe_r <= 1'b1;
      done_r <= 1'b0;
    end else begin
      tdo_r <= tdo_nxt;
      pin_r <= pin_nxt;
      oe_r <= oe_nxt;
      done_r <= done_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // port drive
  assign cell_addr_out = addr_r;
  assign tdo_out = tdo_r;
  assign cfg_error_out = cfg_err_r;
  assign cfg_done_out = done_r;
  assign crc_error_out = pin_r;
  assign crc_error_oe_out = oe_r;
endmodule
`default_nettype wire

// >>> dv/crc_check_monitor.sv
// assertion checker on the crc checker ports
`timescale 1ns/1ps
`default_nettype none
module crc_check_monitor #(
  parameter int CELL_AW = 16,
  parameter logic [CELL_AW-1:0] CELL_LAST = '1
) (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic reconfig_request_n_in,
  input wire crc_check_pkg::cfg_s cfg_in,
  input wire crc_check_pkg::scan_s scan_in,
  input wire logic [3:0] div_n_in,
  input wire logic open_drain_opt_in,
  input wire logic cell_bit_in,
  input wire logic [CELL_AW-1:0] cell_addr_out,
  input wire logic tdo_out,
  input wire logic cfg_error_out,
  input wire logic cfg_done_out,
  input wire logic crc_error_out,
  input wire logic crc_error_oe_out
);
  logic clr, lvl, lvl_r, sh;
  logic [19:0] cnt_r;
  logic [5:0] run_r;
  logic [31:0] chain_r;
  assign clr = rst_in || !reconfig_request_n_in;
  assign lvl = crc_error_oe_out ? crc_error_out : 1'b1;
  assign sh = scan_in.shift_dr && cfg_done_out &&
    scan_in.ir == crc_check_pkg::LOAD_REF_INSTR;
  always_ff @(posedge core_clk_in) begin
    lvl_r <= lvl;
    cnt_r <= (clr || lvl != lvl_r) ? '0 : cnt_r + 1'b1;
    run_r <= (sh && !clr) ? run_r + 1'b1 : '0;
    if (sh) chain_r <= {scan_in.tdi, chain_r[31:1]};
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (clr);
  chk_quiet_config:
    assert property (!cfg_done_out |-> !lvl)
    else $error("error pin active outside user mode");
  chk_err_pass_hold:
    assert property ($changed(lvl) |->
      int'(cnt_r) >= ((int'(CELL_LAST) + 33) << div_n_in) - 1)
    else $error("error pin changed within one pass");
  chk_push_pull:
    assert property (!open_drain_opt_in |-> crc_error_oe_out)
    else $error("error pin released in push-pull mode");
  chk_drain_low:
    assert property (cfg_done_out && open_drain_opt_in |-> !crc_error_out)
    else $error("open drain pin driven high");
  chk_chain_out:
    assert property (sh && run_r >= 6'd31 |=> tdo_out == chain_r[0])
    else $error("reference chain output wrong");
  chk_done_hold:
    assert property (cfg_done_out |=> cfg_done_out)
    else $error("user mode left without reset");
  chk_cfg_err_hold:
    assert property (cfg_error_out |=> cfg_error_out && !cfg_done_out)
    else $error("config error cleared or user mode entered");
  chk_reconfig_clear:
    assert property (@(posedge core_clk_in) disable iff (rst_in)
      !reconfig_request_n_in [*5] |-> !cfg_done_out && !lvl)
    else $error("reconfig request did not reset");
endmodule
bind config_memory_crc_checker crc_check_monitor #(.CELL_AW(CELL_AW),
  .CELL_LAST(CELL_LAST)) mon_i (.core_clk_in(core_clk_in), .rst_in(rst_in),
  .reconfig_request_n_in(reconfig_request_n_in), .cfg_in(cfg_in),
  .scan_in(scan_in), .div_n_in(div_n_in),
  .open_drain_opt_in(open_drain_opt_in), .cell_bit_in(cell_bit_in),
  .cell_addr_out(cell_addr_out), .tdo_out(tdo_out),
  .cfg_error_out(cfg_error_out), .cfg_done_out(cfg_done_out),
  .crc_error_out(crc_error_out), .crc_error_oe_out(crc_error_oe_out));
`default_nettype wire

// >>> dv/cell_store_model.sv
// config cells and error pin pull-up on the system side
`timescale 1ns/1ps
`default_nettype none
module cell_store_model (
  input wire logic [15:0] cells_in,
  input wire logic [15:0] addr_in,
  input wire logic err_in,
  input wire logic err_oe_in,
  output logic cell_bit_out,
  output logic err_pin_out
);
  // config cells 0 to 15 answer, any other address reads inverted cell 0
  assign cell_bit_out = addr_in < 16'd16 ? cells_in[addr_in[3:0]] :
    ~cells_in[0];
  // pull-up when the pin is released
  assign err_pin_out = err_oe_in ? err_in : 1'b1;
endmodule
`default_nettype wire

// >>> dv/test_config_memory_crc_checker.sv
// self-checking bench for the config memory crc checker
`timescale 1ns/1ps
`default_nettype none
module test_config_memory_crc_checker;
  logic core_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic reconfig_n = 1'b1;
  crc_check_pkg::cfg_s cfg = '0;
  crc_check_pkg::scan_s scan = {crc_check_pkg::LOAD_REF_INSTR, 4'h0};
  logic [3:0] div_n = 4'h1;
  logic od = 1'b0;
  logic [15:0] cells = 16'h0000;
  logic [15:0] addr;
  logic cell_bit, tdo, cfg_err, done, err, oe, pin;
  logic [31:0] ref_v, bad, rd;
  int n_errors = 0;
  int checked = 0;

  always #5 core_clk_in = ~core_clk_in;

  config_memory_crc_checker #(.CELL_AW(16), .CELL_LAST(16'h000f))
    config_memory_crc_checker_i (.core_clk_in(core_clk_in),
    .rst_in(rst_in), .reconfig_request_n_in(reconfig_n), .cfg_in(cfg),
    .scan_in(scan), .div_n_in(div_n), .open_drain_opt_in(od),
    .cell_bit_in(cell_bit), .cell_addr_out(addr), .tdo_out(tdo),
    .cfg_error_out(cfg_err), .cfg_done_out(done), .crc_error_out(err),
    .crc_error_oe_out(oe));
  cell_store_model cell_store_model_i (.cells_in(cells), .addr_in(addr),
    .err_in(err), .err_oe_in(oe), .cell_bit_out(cell_bit),
    .err_pin_out(pin));

  function automatic logic [31:0] crc_step(logic [31:0] c, logic b,
      logic [31:0] poly, int w);
    logic fb;
    fb = c[w-1] ^ b;
    c = c << 1;
    if (fb) c = c ^ poly;
    return w == 32 ? c : c & 32'h0000ffff;
  endfunction

  function automatic logic [31:0] cell_ref(logic [15:0] m);
    logic [31:0] c;
    c = crc_check_pkg::CRC_INIT;
    for (int a = 0; a < 16; a++) c = crc_step(c, m[a],
      crc_check_pkg::CRC_POLY, 32);
    return c;
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic beat(input logic d, fe, lf, rb);
    @(posedge core_clk_in);
    cfg <= {1'b1, d, fe, lf, rb};
  endtask

  task automatic frame(input logic [7:0] d, input logic lf, bad_crc);
    logic [31:0] c;
    c = {16'h0000, crc_check_pkg::FRAME_INIT};
    for (int i = 7; i >= 0; i--) begin
      beat(d[i], i == 0, lf, 1'b0);
      c = crc_step(c, d[i], {16'h0000, crc_check_pkg::FRAME_POLY}, 16);
    end
    if (lf) for (int i = 31; i >= 0; i--) beat(ref_v[i], 1'b1, 1'b1,
      ref_v[i]);
    for (int i = 15; i >= 0; i--) beat(c[i] ^ (bad_crc && i == 0), 1'b0,
      lf, 1'b0);
  endtask

  task automatic scan_xfer(input logic [31:0] wr, output logic [31:0] got);
    @(posedge core_clk_in);
    scan.capture_dr <= 1'b1;
    for (int i = 0; i < 32; i++) begin
      @(posedge core_clk_in);
      scan.capture_dr <= 1'b0;
      scan.shift_dr <= 1'b1;
      scan.tdi <= wr[i];
      #1 got[i] = tdo;
    end
    @(posedge core_clk_in);
    scan.shift_dr <= 1'b0;
    scan.update_dr <= 1'b1;
    @(posedge core_clk_in);
    scan.update_dr <= 1'b0;
  endtask

  task automatic wait_passes(input int k);
    repeat ((k * 48 << div_n) + 4) @(posedge core_clk_in);
    #1;
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    rd = $urandom(32'h9365ad5a);
    for (int r = 0; r < 3; r++) begin
      if (r > 0) @(posedge core_clk_in);
      cells <= 16'($urandom());
      div_n <= 4'(r + 1);
      od <= r == 1;
      rst_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      rst_in <= 1'b0;
      ref_v = cell_ref(cells);
      scan_xfer($urandom(), rd);
      check(rd, 32'h00000000);
      frame(8'($urandom()), 1'b0, r == 2);
      frame(8'($urandom()), 1'b1, 1'b0);
      @(posedge core_clk_in);
      cfg <= '0;
      repeat (3) @(posedge core_clk_in);
      check(done, r != 2);
      check(cfg_err, r == 2);
      if (r < 2) begin
        scan_xfer(ref_v, rd);
        check(rd, ref_v);
        wait_passes(2);
        check(pin, 1'b0);
        bad = ref_v ^ ($urandom() | 32'h1);
        scan_xfer(bad, rd);
        check(rd, ref_v);
        repeat ((48 << div_n) - 3) @(posedge core_clk_in);
        #1 check(pin, 1'b0);
        wait_passes(2);
        check(pin, 1'b1);
        scan_xfer(ref_v, rd);
        check(rd, bad);
        wait_passes(2);
        check(pin, 1'b0);
        @(posedge core_clk_in);
        reconfig_n <= 1'b0;
        repeat (5) @(posedge core_clk_in);
        reconfig_n <= 1'b1;
        #1 check(done, 1'b0);
        check(pin, 1'b0);
      end else begin
        scan_xfer(ref_v, rd);
        scan_xfer(~ref_v, rd);
        check(rd, 32'h00000000);
      end
      $display("test %0d done", r);
    end
    print_verdict();
  end

  initial begin
    repeat (30000) @(posedge core_clk_in);
    n_errors++;
    print_verdict();
  end
endmodule
`default_nettype wire
